// ===== rtl/pss_pkg.sv
// package for the power save and scaling controller
package pss_pkg;

   // register indices of the plain register port
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_RESTART = 4'h1;
   localparam logic [3:0] ADDR_WAKEEN = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_CAUSE  = 4'h4;

   // control register field positions
   localparam int CTRL_DEEP   = 0;
   localparam int CTRL_RETAIN = 1;
   localparam int CTRL_BACKUP = 2;
   localparam int CTRL_FASTW  = 3;
   localparam int CTRL_SLP_L  = 4;
   localparam int CTRL_LVL_L  = 6;
   localparam int CTRL_PSREQ = 8;
   localparam int CTRL_RUN_L = 9;

   // wake enable field positions
   localparam int WEN_STABLE = 0;
   localparam int WEN_PER  = 1;

   // restart oscillator selection
   localparam logic [1:0] OSC_SYS_RC  = 2'h0;
   localparam logic [1:0] OSC_FAST_RC = 2'h1;

   localparam logic [1:0] LVL_LOW       = 2'h1;
   localparam logic [1:0] LVL_RESET     = 2'h0;
   localparam logic [1:0] SLEEP_AHB_ON  = 2'h0;
   localparam logic [1:0] SLEEP_APB_OFF = 2'h2;
   localparam logic [1:0] CAUSE_STABLE  = 2'h1;
   localparam logic [1:0] CAUSE_PERIPH  = 2'h2;
   localparam logic [1:0] RUN_BASE      = 2'h0;
   localparam logic [1:0] SLEEP_SRC_OFF = 2'h3;

   // settle times in ns and derived cycle counts at 25 MHz
   localparam int CLK_NS          = 40;
   localparam int REG_READY_NS    = 20000;
   localparam int FAST_SWITCH_NS  = 2000;
   localparam int SYS_RC_WAKE_NS  = 3000;
   localparam int FAST_RC_WAKE_NS = 400;
   localparam int SRC_WAKE_NS     = 1000;
   localparam int FLASH_WAKE_NS   = 800;
   localparam int CORE_RST_NS     = 4000;
   localparam int REG_READY_CYC   = REG_READY_NS / CLK_NS;
   localparam int FAST_SW_CYC     = (FAST_SWITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYS_RC_CYC      = (SYS_RC_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int FAST_RC_CYC     = (FAST_RC_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SRC_WAKE_CYC    = (SRC_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLASH_CYC       = (FLASH_WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CORE_RST_CYC    = (CORE_RST_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W           = 10;

   typedef enum logic [6:0] {
      ST_RUN     = 7'h01,
      ST_SLEEP   = 7'h02,
      ST_DEEP    = 7'h04,
      ST_BACKUP  = 7'h08,
      ST_SWITCH  = 7'h10,
      ST_OSC     = 7'h20,
      ST_FLASH   = 7'h40
   } pss_state_t;

   // clock and power gates driven toward the chip
   typedef struct packed {
      logic cpu_clk_en;
      logic ahb_clk_en;
      logic apb_clk_en;
      logic src_clk_en;
      logic sys_rc_en;
      logic slow_clk_en;
      logic core_pwr_en;
      logic core_rst;
   } pss_gates_t;

   // backup wake sources
   typedef struct packed {
      logic ext_irq;
      logic bod_main;
      logic bod_core;
      logic timer_evt;
      logic wdt_irq;
   } pss_bkwake_t;

endpackage : pss_pkg

// ===== rtl/pss_ctrl.sv
// power save mode sequencer and run-time power scaling controller
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module pss_ctrl
   import pss_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   input  wire logic        wfi_i,
   input  wire logic        irq_i,
   input  wire logic        periph_wake_i,
   input  wire logic        reg_ready_i,
   input  wire pss_bkwake_t bk_wake_i,
   input  wire logic        bk_reset_i,
   output pss_gates_t       gates_o,
   output logic [1:0]       reg_level_o,
   output logic [1:0]       run_mode_o,
   output logic [1:0]       restart_osc_o,
   output logic             flash_1ws_o,
   output logic             pm_wake_irq_o,
   output logic             feat_hs_en_o
);

   pss_state_t       state_q;
   logic             deep_q, retain_q, backup_q, fastw_q, psreq_q;
   logic [1:0]       sleep_lvl_q, lvl_field_q, lvl_applied_q, run_q, run_saved_q;
   logic [1:0]       fast_osc_q;
   logic [1:0]       wake_en_q;
   logic [1:0]       cause_q;
   logic             stable_q;
   logic [CNT_W-1:0] cnt_q;
   logic             ready_s1_q, ready_s2_q;
   logic [4:0]       bk_s1_q, bk_s2_q;
   logic             rst_s1_q, rst_s2_q, pw_s1_q, pw_s2_q;
   logic             scaling_q;
   logic             src_stopped;
   logic             cnt_done;

   assign cnt_done    = (cnt_q == '0);
   assign src_stopped = (sleep_lvl_q == SLEEP_SRC_OFF);

   // pin synchronisers
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ready_s1_q <= 1'b0;
         ready_s2_q <= 1'b0;
         bk_s1_q    <= '0;
         bk_s2_q    <= '0;
         rst_s1_q   <= 1'b0;
         rst_s2_q   <= 1'b0;
         pw_s1_q    <= 1'b0;
         pw_s2_q    <= 1'b0;
      end else begin
         ready_s1_q <= reg_ready_i;
         ready_s2_q <= ready_s1_q;
         bk_s1_q    <= bk_wake_i;
         bk_s2_q    <= bk_s1_q;
         rst_s1_q   <= bk_reset_i;
         rst_s2_q   <= rst_s1_q;
         pw_s1_q    <= periph_wake_i;
         pw_s2_q    <= pw_s1_q;
      end
   end

   // register writes
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         deep_q      <= 1'b0;
         retain_q    <= 1'b0;
         backup_q    <= 1'b0;
         fastw_q     <= 1'b0;
         sleep_lvl_q <= '0;
         lvl_field_q <= LVL_RESET;
         run_q       <= RUN_BASE;
         fast_osc_q  <= OSC_SYS_RC;
         wake_en_q   <= '0;
      end else if (state_q == ST_BACKUP && rst_s2_q) begin
         run_q    <= RUN_BASE;
         backup_q <= 1'b0;
      end else if (wr_i) begin
         unique case (addr_i)
            ADDR_CTRL: begin
               deep_q      <= wdata_i[CTRL_DEEP];
               retain_q    <= wdata_i[CTRL_RETAIN];
               backup_q    <= wdata_i[CTRL_BACKUP];
               fastw_q     <= wdata_i[CTRL_FASTW];
               sleep_lvl_q <= wdata_i[CTRL_SLP_L +: 2];
               if (state_q == ST_RUN && !psreq_q) begin
                  lvl_field_q <= wdata_i[CTRL_LVL_L +: 2];
               end
               run_q       <= wdata_i[CTRL_RUN_L +: 2];
            end
            ADDR_RESTART: fast_osc_q <= wdata_i[1:0];
            ADDR_WAKEEN:  wake_en_q  <= wdata_i[1:0];
            default: begin
            end
         endcase
      end
   end

   // scaling request flag, cleared by hardware once applied
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         psreq_q <= 1'b0;
      end else if (wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_PSREQ]) begin
         psreq_q <= 1'b1;
      end else if (state_q == ST_SWITCH && scaling_q && cnt_done && ready_s2_q) begin
         psreq_q <= 1'b0;
      end
   end

   // read port, data in the following cycle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         unique case (addr_i)
            ADDR_CTRL:    rdata_o <= {5'h00, run_q, psreq_q, lvl_field_q, sleep_lvl_q,
                                      fastw_q, backup_q, retain_q, deep_q};
            ADDR_RESTART: rdata_o <= {14'h0000, fast_osc_q};
            ADDR_WAKEEN:  rdata_o <= {14'h0000, wake_en_q};
            ADDR_STATUS:  rdata_o <= {15'h0000, stable_q};
            ADDR_CAUSE:   rdata_o <= {14'h0000, cause_q};
            default:      rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   // mode sequencer
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q     <= ST_RUN;
         cnt_q       <= '0;
         scaling_q     <= 1'b0;
         stable_q      <= 1'b1;
         run_saved_q   <= RUN_BASE;
         lvl_applied_q <= LVL_RESET;
      end else begin
         if (!cnt_done) begin
            cnt_q <= cnt_q - 1'b1;
         end
         unique case (state_q)
            ST_RUN: begin
               if (wfi_i && psreq_q && stable_q) begin
                  state_q   <= ST_SWITCH;
                  scaling_q <= 1'b1;
                  stable_q  <= 1'b0;
                  cnt_q     <= CNT_W'(REG_READY_CYC);
               end else if (wfi_i && !deep_q && !backup_q) begin
                  state_q <= ST_SLEEP;
               end else if (wfi_i && deep_q && backup_q) begin
                  state_q     <= ST_BACKUP;
                  run_saved_q <= run_q;
               end else if (wfi_i && deep_q) begin
                  state_q     <= ST_DEEP;
                  run_saved_q <= run_q;
               end
            end
            ST_SLEEP: begin
               if (irq_i) begin
                  state_q <= src_stopped ? ST_OSC : ST_RUN;
                  cnt_q   <= src_stopped ? CNT_W'(SRC_WAKE_CYC) : '0;
               end
            end
            ST_DEEP: begin
               if (wake_en_q[WEN_PER] && pw_s2_q) begin
                  state_q  <= ST_SWITCH;
                  stable_q <= 1'b0;
                  cnt_q    <= fastw_q ? CNT_W'(FAST_SW_CYC) : CNT_W'(REG_READY_CYC);
               end
            end
            ST_BACKUP: begin
               if (rst_s2_q || |bk_s2_q) begin
                  state_q  <= ST_SWITCH;
                  stable_q <= 1'b0;
                  cnt_q    <= CNT_W'(CORE_RST_CYC + REG_READY_CYC);
               end
            end
            ST_SWITCH: begin
               if (scaling_q && cnt_done && ready_s2_q) begin
                  state_q   <= ST_RUN;
                  scaling_q <= 1'b0;
                  // new level reaches the regulator only once the cpu is halted
                  lvl_applied_q <= lvl_field_q;
                  stable_q  <= 1'b1;
               end else if (!scaling_q && cnt_done && (fastw_q || ready_s2_q)) begin
                  state_q <= ST_OSC;
                  cnt_q   <= (fast_osc_q == OSC_FAST_RC) ? CNT_W'(FAST_RC_CYC) : CNT_W'(SYS_RC_CYC);
               end
            end
            ST_OSC: begin
               if (cnt_done) begin
                  // flash wake follows every deep or backup restart
                  state_q <= deep_q ? ST_FLASH : ST_RUN;
                  cnt_q   <= deep_q ? CNT_W'(FLASH_CYC) : '0;
               end
            end
            ST_FLASH: begin
               if (cnt_done) begin
                  state_q <= ST_RUN;
               end
            end
            default: state_q <= ST_RUN;
         endcase
         // regulator catching up after a fast wake
         if (!stable_q && !scaling_q && (state_q == ST_OSC || state_q == ST_FLASH || state_q == ST_RUN)
             && ready_s2_q) begin
            stable_q <= 1'b1;
         end
      end
   end

   // wake cause: bit0 stable event, bit1 peripheral
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cause_q       <= '0;
         pm_wake_irq_o <= 1'b0;
      end else if (state_q == ST_SWITCH && scaling_q && cnt_done && ready_s2_q
                   && wake_en_q[WEN_STABLE]) begin
         cause_q       <= CAUSE_STABLE;
         pm_wake_irq_o <= 1'b1;
      end else if (state_q == ST_DEEP && wake_en_q[WEN_PER] && pw_s2_q) begin
         cause_q       <= CAUSE_PERIPH;
         pm_wake_irq_o <= 1'b1;
      end else if (rd_i && addr_i == ADDR_CAUSE) begin
         pm_wake_irq_o <= 1'b0;
      end
   end

   // gate and output drive
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gates_o       <= '0;
         reg_level_o   <= LVL_RESET;
         run_mode_o    <= RUN_BASE;
         restart_osc_o <= OSC_SYS_RC;
         flash_1ws_o   <= 1'b0;
         feat_hs_en_o  <= 1'b0;
      end else begin
         gates_o.cpu_clk_en  <= (state_q == ST_RUN);
         gates_o.ahb_clk_en  <= (state_q == ST_RUN) || (state_q == ST_SLEEP && sleep_lvl_q == SLEEP_AHB_ON);
         gates_o.apb_clk_en  <= (state_q == ST_RUN) || (state_q == ST_SLEEP && sleep_lvl_q < SLEEP_APB_OFF);
         gates_o.src_clk_en  <= (state_q == ST_RUN) || (state_q == ST_SLEEP && !src_stopped)
                                || state_q == ST_FLASH;
         gates_o.sys_rc_en   <= !(state_q == ST_DEEP || state_q == ST_BACKUP);
         gates_o.slow_clk_en <= 1'b1;
         gates_o.core_pwr_en <= (state_q != ST_BACKUP);
         gates_o.core_rst    <= (state_q == ST_BACKUP) || (state_q == ST_SWITCH && !scaling_q && backup_q);
         reg_level_o         <= lvl_applied_q;
         run_mode_o          <= (state_q == ST_RUN) ? run_q : run_saved_q;
         restart_osc_o       <= fast_osc_q;
         flash_1ws_o         <= !stable_q && !scaling_q;
         feat_hs_en_o        <= (lvl_applied_q != LVL_LOW);
      end
   end

endmodule : pss_ctrl

// ===== dv/pss_ctrl_monitor.sv
// port checker for the power save controller
`timescale 1ns/10ps
module pss_ctrl_monitor
   import pss_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic [3:0]  addr_i,
   input wire logic        rd_i,
   input wire logic        wfi_i,
   input wire logic        irq_i,
   input wire logic [15:0] rdata_o,
   input wire pss_gates_t  gates_o,
   input wire logic [1:0]  reg_level_o,
   input wire logic        pm_wake_irq_o,
   input wire logic        feat_hs_en_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data not zero");
   a_level_feat: assert property (reg_level_o == LVL_LOW && $stable(reg_level_o) |-> !feat_hs_en_o)
      else $error("features on at low level");
   a_level_halted: assert property ($changed(reg_level_o) |-> !gates_o.cpu_clk_en || !$past(gates_o.cpu_clk_en))
      else $error("level changed while cpu ran");
   a_core_off: assert property (!gates_o.core_pwr_en |-> !gates_o.cpu_clk_en)
      else $error("cpu clock without core power");
   a_irq_hold: assert property ($fell(pm_wake_irq_o) |-> $past(rd_i) && $past(addr_i) == ADDR_CAUSE)
      else $error("wake irq dropped without cause read");
   a_wfi_halt: assert property (wfi_i && gates_o.cpu_clk_en && !irq_i |-> ##[1:3] !gates_o.cpu_clk_en)
      else $error("cpu clock kept after wfi");
   a_deep_clocks: assert property (!gates_o.sys_rc_en |->
      !(gates_o.cpu_clk_en | gates_o.ahb_clk_en | gates_o.apb_clk_en | gates_o.src_clk_en))
      else $error("clock running in deep sleep");
   a_slow_on: assert property ($past(rst_b_i, 3) |-> gates_o.slow_clk_en)
      else $error("slow oscillator stopped");
   a_sleep_wake: assert property (irq_i && !gates_o.cpu_clk_en && gates_o.src_clk_en && gates_o.sys_rc_en
      |-> ##[1:4] gates_o.cpu_clk_en)
      else $error("slow sleep wake");
endmodule : pss_ctrl_monitor

bind pss_ctrl pss_ctrl_monitor u_mon (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .rd_i(rd_i),
   .wfi_i(wfi_i), .irq_i(irq_i), .rdata_o(rdata_o), .gates_o(gates_o), .reg_level_o(reg_level_o),
   .pm_wake_irq_o(pm_wake_irq_o), .feat_hs_en_o(feat_hs_en_o));

// ===== dv/power_save_scaling_control_test.sv
// self-checking bench for the power save controller
`timescale 1ns/10ps
module power_save_scaling_control_test
   import pss_pkg::*;
;
   logic        mclk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic        wfi_i = 1'b0, irq_i = 1'b0, periph_wake_i = 1'b0, reg_ready_i = 1'b1, bk_reset_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000, rdata_o, d;
   pss_bkwake_t bk_wake_i = '0;
   pss_gates_t  gates_o;
   logic [1:0]  reg_level_o, run_mode_o, restart_osc_o;
   logic        flash_1ws_o, pm_wake_irq_o, feat_hs_en_o, seen_fw;
   int          mismatches = 0, total_checks = 0, n;
   always #20 mclk_i = ~mclk_i;
   pss_ctrl u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .wfi_i(wfi_i), .irq_i(irq_i), .periph_wake_i(periph_wake_i),
      .reg_ready_i(reg_ready_i), .bk_wake_i(bk_wake_i), .bk_reset_i(bk_reset_i), .gates_o(gates_o),
      .reg_level_o(reg_level_o), .run_mode_o(run_mode_o), .restart_osc_o(restart_osc_o),
      .flash_1ws_o(flash_1ws_o), .pm_wake_irq_o(pm_wake_irq_o), .feat_hs_en_o(feat_hs_en_o));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   task automatic sleep_now();
      @(posedge mclk_i);
      wfi_i <= 1'b1;
      @(posedge mclk_i);
      wfi_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask : sleep_now
   // cycles until the cpu clock is back, bounded
   task automatic wait_cpu();
      n = 0;
      while (gates_o.cpu_clk_en !== 1'b1 && n < 2000) begin
         @(posedge mclk_i);
         n++;
         if (flash_1ws_o === 1'b1) seen_fw = 1'b1;
      end
      @(posedge mclk_i);
   endtask : wait_cpu
   task automatic t_reset();
      #1;
      chk("cpu_clk", 1'b1, gates_o.cpu_clk_en);
      chk("run_mode", RUN_BASE, run_mode_o);
      chk("level", LVL_RESET, reg_level_o);
      chk("feat", 1'b1, feat_hs_en_o);
      rd(4'hF);
      chk("unmapped", 16'h0000, d);
      rd(ADDR_STATUS);
      chk("stable", 16'h0001, d & 16'h0001);
      $display("done reset");
   endtask : t_reset
   task automatic t_sleep();
      for (int l = 0; l < 2; l++) begin
         wr(ADDR_CTRL, l ? 16'h0430 : 16'h0400);
         sleep_now();
         chk("cpu_off", 1'b0, gates_o.cpu_clk_en);
         chk("apb", !l, gates_o.apb_clk_en);
         chk("src", !l, gates_o.src_clk_en);
         chk("ahb", !l, gates_o.ahb_clk_en);
         @(posedge mclk_i);
         irq_i <= 1'b1;
         wait_cpu();
         irq_i <= 1'b0;
         chk("sleep_lat", 1'b1, l ? n >= SRC_WAKE_CYC : n < 5);
         chk("run_back", 2'h2, run_mode_o);
      end
      $display("done sleep");
   endtask : t_sleep
   task automatic t_scale();
      wr(ADDR_WAKEEN, 16'h0001);
      wr(ADDR_CTRL, 16'h0440);
      wr(ADDR_CTRL, 16'h0540);
      chk("level_wait", LVL_RESET, reg_level_o);
      sleep_now();
      wait_cpu();
      chk("scale_lat", 1'b1, n >= REG_READY_CYC - 5);
      chk("level_new", LVL_LOW, reg_level_o);
      chk("feat_low", 1'b0, feat_hs_en_o);
      chk("wake_irq", 1'b1, pm_wake_irq_o);
      rd(ADDR_CAUSE);
      chk("cause_stable", {14'h0000, CAUSE_STABLE}, d);
      rd(ADDR_CTRL);
      chk("irq_clr", 1'b0, pm_wake_irq_o);
      chk("req_clr", 16'h0000, d & 16'h0100);
      $display("done scale");
   endtask : t_scale
   task automatic t_deep();
      wr(ADDR_WAKEEN, 16'h0002);
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_RESTART, p ? 16'h0000 : 16'h0001);
         wr(ADDR_CTRL, p ? 16'h0443 : 16'h0449);
         sleep_now();
         chk("sys_rc", 1'b0, gates_o.sys_rc_en);
         chk("slow", 1'b1, gates_o.slow_clk_en);
         @(posedge mclk_i);
         reg_ready_i   <= (p == 1);
         periph_wake_i <= 1'b1;
         repeat (4) @(posedge mclk_i);
         periph_wake_i <= 1'b0;
         seen_fw = 1'b0;
         wait_cpu();
         reg_ready_i <= 1'b1;
         chk("deep_lat", 1'b1, p ? n >= REG_READY_CYC : n < REG_READY_CYC);
         chk("osc", p ? OSC_SYS_RC : OSC_FAST_RC, restart_osc_o);
         if (p == 0) chk("flash_ws", 1'b1, seen_fw);
         chk("run_back", 2'h2, run_mode_o);
         chk("deep_irq", 1'b1, pm_wake_irq_o);
         rd(ADDR_CAUSE);
         chk("cause_periph", {14'h0000, CAUSE_PERIPH}, d);
      end
      $display("done deep");
   endtask : t_deep
   task automatic t_backup();
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_CTRL, 16'h0445);
         sleep_now();
         chk("core_pwr", 1'b0, gates_o.core_pwr_en);
         chk("core_rst", 1'b1, gates_o.core_rst);
         @(posedge mclk_i);
         if (i == 5) bk_reset_i <= 1'b1;
         else bk_wake_i <= pss_bkwake_t'(5'h01 << i);
         repeat (4) @(posedge mclk_i);
         bk_reset_i <= 1'b0;
         bk_wake_i  <= '0;
         wait_cpu();
         chk("bk_lat", 1'b1, n >= CORE_RST_CYC + REG_READY_CYC - 8);
         chk("bk_run", i == 5 ? RUN_BASE : 2'h2, run_mode_o);
      end
      $display("done backup");
   endtask : t_backup
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(posedge mclk_i);
      t_reset();
      t_sleep();
      t_scale();
      t_deep();
      t_backup();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      mismatches++;
      close_out();
   end
endmodule : power_save_scaling_control_test
